// [core/xed_core.sv]
// Decode and execute core for the exclusive-OR and extended operation group.
`timescale 1ns/1ps
`default_nettype none
`include "xed_defs.svh"

module xed_core #(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire xed_pkg::xed_bus_s bus,
  output logic [23:0]           bus_rdata,
  input  wire logic             instr_valid,
  input  wire logic [15:0]      instr_word,
  output logic                  instr_ready,
  output logic [20:0]           pc_out
);

  // ****************************************
  // Reset release and quarter phases.
  // ****************************************
  logic                 rst_meta_q;
  logic                 rst_sync_q;
  logic [1:0]           q_q;
  xed_pkg::xed_state_e  st_q;
  xed_pkg::xed_op_s     op_q;
  logic [11:0]          dst_q;
  logic [7:0]           opnd_q;
  logic [7:0]           res_q;
  logic                 ext_q;
  logic [7:0]           working_register_q;
  logic                 n_q;
  logic                 z_q;
  logic [7:0]           bsr_q;
  logic [11:0]          fsr_q [3];
  logic [7:0]           pc_high_latch_q;
  logic [7:0]           pc_upper_latch_q;
  logic [20:0]          pc_q;
  logic [11:0]          maddr_q;
  logic [7:0]           mem_q [4096];
  logic [20:0]          stk_q [STACK_DEPTH];
  logic [7:0]           sp_q;
  logic [20:0]          return_stack_top;
  logic                 take;
  logic                 q4;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // The four quarters run freely so that every instruction cycle is four clocks.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      q_q <= 2'h0;
    end else begin
      q_q <= q_q + 2'h1;
    end
  end

  // ****************************************
  // Address forming and decode.
  // ****************************************
  function automatic logic [11:0] index_addr(logic [11:0] frame, logic [7:0] off);
    return frame + {4'h0, off};
  endfunction

  function automatic logic [11:0] file_addr(logic [7:0] f, logic a, logic ext,
                                            logic [7:0] bank, logic [11:0] frame);
    if (!a && ext && (f <= `XED_IDX_MAX)) begin
      return index_addr(frame, f);
    end else if (!a) begin
      return (f < `XED_ACC_SPLIT) ? {4'h0, f} : {`XED_ACC_HI, f};
    end else begin
      return {bank[3:0], f};
    end
  endfunction

  function automatic xed_pkg::xed_op_s decode_word(logic [15:0] w, logic ext,
                                                   logic [7:0] bank, logic [11:0] frame);
    xed_pkg::xed_op_s o;
    o.kind      = xed_pkg::OP_NONE;
    o.dest_file = w[9];
    o.addr      = file_addr(w[7:0], w[8], ext, bank, frame);
    o.sel       = w[7:6];
    o.lit       = w[7:0];
    if (w[15:10] == `XED_OP_XOR) begin
      o.kind = xed_pkg::OP_XOR;
    end else if (ext) begin
      if (w[15:8] == `XED_OP_PADD) begin
        o.kind = (w[7:6] == `XED_SEL_FRAME) ? xed_pkg::OP_FADD : xed_pkg::OP_PADD;
      end else if (w[15:8] == `XED_OP_PSUB) begin
        o.kind = (w[7:6] == `XED_SEL_FRAME) ? xed_pkg::OP_FSUB : xed_pkg::OP_PSUB;
      end else if (w[15:8] == `XED_OP_PUSH) begin
        o.kind = xed_pkg::OP_PUSH;
      end else if (w[15:8] == `XED_OP_MOVE) begin
        o.kind = w[7] ? xed_pkg::OP_INDEXED_MOVE_TO_INDEXED : xed_pkg::OP_INDEXED_MOVE_TO_FILE;
        o.addr = index_addr(frame, {1'b0, w[6:0]});
      end else if (w == `XED_OP_CALL_VIA_WORKING_REG) begin
        o.kind = xed_pkg::OP_CALL_VIA_WORKING_REG;
      end
    end
    return o;
  endfunction

  // ****************************************
  // Sequencing.
  // ****************************************
  assign instr_ready = ((st_q == xed_pkg::ST_FETCH) || (st_q == xed_pkg::ST_WORD2))
                       && (q_q == 2'h0);
  assign take        = instr_ready && instr_valid;
  assign q4          = (st_q == xed_pkg::ST_EXEC) && (q_q == `XED_Q_LAST);
  assign pc_out      = pc_q;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      st_q <= xed_pkg::ST_FETCH;
    end else begin
      unique case (st_q)
        xed_pkg::ST_FETCH: begin
          if (take) begin
            st_q <= xed_pkg::ST_EXEC;
          end
        end
        xed_pkg::ST_EXEC: begin
          if (q_q == `XED_Q_LAST) begin
            unique case (op_q.kind)
              xed_pkg::OP_FADD, xed_pkg::OP_FSUB, xed_pkg::OP_CALL_VIA_WORKING_REG: begin
                st_q <= xed_pkg::ST_NOP2;
              end
              xed_pkg::OP_INDEXED_MOVE_TO_FILE, xed_pkg::OP_INDEXED_MOVE_TO_INDEXED: begin
                st_q <= xed_pkg::ST_WORD2;
              end
              default: begin
                st_q <= xed_pkg::ST_FETCH;
              end
            endcase
          end
        end
        xed_pkg::ST_NOP2: begin
          if (q_q == `XED_Q_LAST) begin
            st_q <= xed_pkg::ST_FETCH;
          end
        end
        xed_pkg::ST_WORD2: begin
          if (take) begin
            // A second word without its prefix cancels the move.
            st_q <= (instr_word[15:12] == `XED_OP_WORD2) ? xed_pkg::ST_MOVE2
                                                          : xed_pkg::ST_FETCH;
          end
        end
        xed_pkg::ST_MOVE2: begin
          if (q_q == `XED_Q_LAST) begin
            st_q <= xed_pkg::ST_FETCH;
          end
        end
      endcase
    end
  end

  // Decode in the first quarter, with pointers that only change in the last.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      op_q  <= '0;
      dst_q <= `XED_PTR_RST;
    end else if (take && (st_q == xed_pkg::ST_FETCH)) begin
      op_q <= decode_word(instr_word, ext_q, bsr_q, fsr_q[2]);
    end else if (take) begin
      dst_q <= (op_q.kind == xed_pkg::OP_INDEXED_MOVE_TO_INDEXED) ? index_addr(fsr_q[2], {1'b0, instr_word[6:0]})
                                                 : instr_word[11:0];
    end
  end

  // Operand read in the second quarter, processing in the third.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      opnd_q <= `XED_BYTE_RST;
      res_q  <= `XED_BYTE_RST;
    end else if ((st_q == xed_pkg::ST_EXEC) && (q_q == 2'h1)) begin
      opnd_q <= mem_q[op_q.addr];
    end else if ((st_q == xed_pkg::ST_EXEC) && (q_q == 2'h2)) begin
      res_q <= working_register_q ^ opnd_q;
    end
  end

  // ****************************************
  // Write quarter effects.
  // ****************************************
  logic        is_xor;
  logic        working_register_we;
  logic        mem_we;
  logic [11:0] mem_wa;
  logic [7:0]  mem_wd;
  logic [2:0]  ptr_we;
  logic [11:0] ptr_wval;
  logic        push;
  logic        pop;

  assign is_xor  = q4 && (op_q.kind == xed_pkg::OP_XOR);
  assign working_register_we = is_xor && !op_q.dest_file;
  assign push    = q4 && (op_q.kind == xed_pkg::OP_CALL_VIA_WORKING_REG);
  assign pop     = q4 && ((op_q.kind == xed_pkg::OP_FADD) || (op_q.kind == xed_pkg::OP_FSUB));
  assign return_stack_top     = (sp_q == 8'h00) ? `XED_PC_RST : stk_q[sp_q[2:0] - 3'h1];

  always_comb begin
    mem_we = 1'b0;
    mem_wa = op_q.addr;
    mem_wd = res_q;
    if (is_xor && op_q.dest_file) begin
      mem_we = 1'b1;
    end else if (q4 && (op_q.kind == xed_pkg::OP_PUSH)) begin
      mem_we = 1'b1;
      mem_wa = fsr_q[2];
      mem_wd = op_q.lit;
    end else if ((st_q == xed_pkg::ST_MOVE2) && (q_q == `XED_Q_LAST)) begin
      mem_we = 1'b1;
      mem_wa = dst_q;
      mem_wd = opnd_q;
    end
  end

  always_comb begin
    ptr_we   = 3'h0;
    ptr_wval = fsr_q[2];
    if (q4) begin
      unique case (op_q.kind)
        xed_pkg::OP_PADD: begin
          ptr_we[op_q.sel] = 1'b1;
          ptr_wval         = fsr_q[op_q.sel] + {6'h00, op_q.lit[5:0]};
        end
        xed_pkg::OP_PSUB: begin
          ptr_we[op_q.sel] = 1'b1;
          ptr_wval         = fsr_q[op_q.sel] - {6'h00, op_q.lit[5:0]};
        end
        xed_pkg::OP_FADD: begin
          ptr_we[2] = 1'b1;
          ptr_wval  = fsr_q[2] + {6'h00, op_q.lit[5:0]};
        end
        xed_pkg::OP_FSUB: begin
          ptr_we[2] = 1'b1;
          ptr_wval  = fsr_q[2] - {6'h00, op_q.lit[5:0]};
        end
        xed_pkg::OP_PUSH: begin
          ptr_we[2] = 1'b1;
          ptr_wval  = fsr_q[2] - 12'h001;
        end
        default: begin
          ptr_we = 3'h0;
        end
      endcase
    end
  end

  // ****************************************
  // Architectural state.
  // ****************************************
  // Core updates win over a bus write in the same clock so no result is lost.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      working_register_q <= `XED_BYTE_RST;
    end else if (working_register_we) begin
      working_register_q <= res_q;
    end else if (bus.wr && (bus.addr == `XED_REG_WORKING_REGISTER)) begin
      working_register_q <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      n_q <= 1'b0;
      z_q <= 1'b0;
    end else if (is_xor) begin
      n_q <= res_q[7];
      z_q <= (res_q == 8'h00);
    end else if (bus.wr && (bus.addr == `XED_REG_STATUS)) begin
      n_q <= bus.wdata[`XED_STAT_N];
      z_q <= bus.wdata[`XED_STAT_Z];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ext_q    <= `XED_CFG_RST;
      bsr_q    <= `XED_BYTE_RST;
      pc_high_latch_q <= `XED_BYTE_RST;
      pc_upper_latch_q <= `XED_BYTE_RST;
      maddr_q  <= `XED_PTR_RST;
    end else if (bus.wr) begin
      unique case (bus.addr)
        `XED_REG_CFG:    ext_q    <= bus.wdata[`XED_CFG_EXT];
        `XED_REG_BSR:    bsr_q    <= bus.wdata[7:0];
        `XED_REG_PC_HIGH_LATCH: pc_high_latch_q <= bus.wdata[7:0];
        `XED_REG_PC_UPPER_LATCH: pc_upper_latch_q <= bus.wdata[7:0];
        `XED_REG_MADDR:  maddr_q  <= bus.wdata[11:0];
        default:         maddr_q  <= maddr_q;
      endcase
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_ptr
    always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
        fsr_q[i] <= `XED_PTR_RST;
      end else if (ptr_we[i]) begin
        fsr_q[i] <= ptr_wval;
      end else if (bus.wr && (bus.addr == (`XED_REG_FSR0 + 4'(i)))) begin
        fsr_q[i] <= bus.wdata[11:0];
      end
    end
  end

  // Data memory has no reset; software initialises it through the window.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end else if (bus.wr && (bus.addr == `XED_REG_MDATA)) begin
      mem_q[maddr_q] <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pc_q <= `XED_PC_RST;
    end else if (push) begin
      pc_q <= {pc_upper_latch_q[4:0], pc_high_latch_q, working_register_q};
    end else if (pop) begin
      pc_q <= return_stack_top;
    end else if (take) begin
      pc_q <= pc_q + `XED_PC_STEP;
    end
  end

  // A full stack drops the push and an empty one returns to address zero.
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sp_q <= 8'h00;
    end else if (push && (sp_q < 8'(STACK_DEPTH))) begin
      sp_q <= sp_q + 8'h01;
    end else if (pop && (sp_q != 8'h00)) begin
      sp_q <= sp_q - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (push && (sp_q < 8'(STACK_DEPTH))) begin
      stk_q[sp_q[2:0]] <= pc_q;
    end
  end

  // ****************************************
  // Register read port.
  // ****************************************
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      bus_rdata <= 24'h000000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `XED_REG_CFG:    bus_rdata <= {23'h000000, ext_q};
        `XED_REG_WORKING_REGISTER:   bus_rdata <= {16'h0000, working_register_q};
        `XED_REG_STATUS: bus_rdata <= {19'h00000, n_q, 1'b0, z_q, 2'h0};
        `XED_REG_BSR:    bus_rdata <= {16'h0000, bsr_q};
        4'h4, 4'h5, 4'h6: bus_rdata <= {12'h000, fsr_q[bus.addr[1:0]]};
        `XED_REG_PC_HIGH_LATCH: bus_rdata <= {16'h0000, pc_high_latch_q};
        `XED_REG_PC_UPPER_LATCH: bus_rdata <= {16'h0000, pc_upper_latch_q};
        `XED_REG_PC:     bus_rdata <= {3'h0, pc_q};
        `XED_REG_TOS:    bus_rdata <= {3'h0, return_stack_top};
        `XED_REG_MADDR:  bus_rdata <= {12'h000, maddr_q};
        `XED_REG_MDATA:  bus_rdata <= {16'h0000, mem_q[maddr_q]};
        default:         bus_rdata <= 24'h000000;
      endcase
    end else begin
      bus_rdata <= 24'h000000;
    end
  end

endmodule // xed_core

`default_nettype wire

// [core/xed_defs.svh]
// Constants for the exclusive-OR and extended operation decoder.
// Overview of operation
// - Decode 0001 10da ffff ffff; XOR working register with file register, one cycle.
// - Destination bit 0 writes working register; 1 writes the file register back.
// - Bank-access bit 0 selects access bank; 1 uses bank select register.
// - Extension on, access bit 0, operand at most 5Fh: indexed from frame pointer.
// - XOR updates only negative and zero flags from its result.
// - Extension enable bit resets to its unprogrammed state, which enables extensions.
// - Eight added instructions and indexed literal offset mode, all gated by enable.
// - Each extended instruction except the working register call alters a pointer or uses pointer plus offset.
// - Pointer add E8 and subtract E9: select by ff, one cycle, no flags.
// - Pointer field 11 adjusts frame pointer then returns; two cycles, no flags.
// - Word 0014h calls to working register target over two cycles, no flags.
// - Push literal EA stores literal at frame pointer then decrements it.
// - Pointer add adds zero-extended six-bit literal to the whole pointer.
// - Call pushes next address, loads pc from latches and working register.
// - Indexed move source is frame pointer plus offset; destination twelve-bit address, or frame pointer plus offset when indexed.
`ifndef XED_DEFS_SVH
`define XED_DEFS_SVH

// ****************************************
// Opcode patterns.
// ****************************************
`define XED_OP_XOR      6'h06
`define XED_OP_PADD     8'he8
`define XED_OP_PSUB     8'he9
`define XED_OP_PUSH     8'hea
`define XED_OP_MOVE     8'heb
`define XED_OP_CALL_VIA_WORKING_REG    16'h0014
`define XED_OP_WORD2    4'hf
`define XED_SEL_FRAME   2'h3
`define XED_IDX_MAX     8'h5f
`define XED_ACC_SPLIT   8'h60
`define XED_ACC_HI      4'hf
`define XED_PC_STEP     21'h000002

// ****************************************
// Register offsets and fields.
// ****************************************
`define XED_REG_CFG     4'h0
`define XED_REG_WORKING_REGISTER    4'h1
`define XED_REG_STATUS  4'h2
`define XED_REG_BSR     4'h3
`define XED_REG_FSR0    4'h4
`define XED_REG_PC_HIGH_LATCH  4'h7
`define XED_REG_PC_UPPER_LATCH  4'h8
`define XED_REG_PC      4'h9
`define XED_REG_TOS     4'ha
`define XED_REG_MADDR   4'hb
`define XED_REG_MDATA   4'hc
`define XED_STAT_N      4
`define XED_STAT_Z      2
`define XED_CFG_EXT     0
`define XED_CFG_RST     1'b1
`define XED_BYTE_RST    8'h00
`define XED_PTR_RST     12'h000
`define XED_PC_RST      21'h000000
`define XED_Q_LAST      2'h3

`endif

// [core/xed_pkg.sv]
// Types shared by the exclusive-OR and extended operation decoder.
package xed_pkg;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_EXEC  = 3'b001,
    ST_NOP2  = 3'b010,
    ST_WORD2 = 3'b011,
    ST_MOVE2 = 3'b100
  } xed_state_e;

  typedef enum logic [3:0] {
    OP_NONE  = 4'b0000,
    OP_XOR   = 4'b0001,
    OP_PADD  = 4'b0010,
    OP_PSUB  = 4'b0011,
    OP_FADD  = 4'b0100,
    OP_FSUB  = 4'b0101,
    OP_CALL_VIA_WORKING_REG = 4'b0110,
    OP_PUSH  = 4'b0111,
    OP_INDEXED_MOVE_TO_FILE = 4'b1000,
    OP_INDEXED_MOVE_TO_INDEXED = 4'b1001
  } xed_kind_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [23:0] wdata;
  } xed_bus_s;

  typedef struct packed {
    xed_kind_e   kind;
    logic        dest_file;
    logic [11:0] addr;
    logic [1:0]  sel;
    logic [7:0]  lit;
  } xed_op_s;

endpackage

// [testbench/testbench.sv]
// Self-checking bench for the exclusive-OR and extended operation decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  // ****************************************
  // Signals, tasks and expectation functions.
  // ****************************************
  logic              clk, rst_n, slow, d, a, ext, o;
  xed_pkg::xed_bus_s bus;
  logic [23:0]       bus_rdata;
  logic              instr_valid, instr_ready;
  logic [15:0]       instr_word;
  logic [20:0]       pc_out, exp_pc, ret;
  logic [7:0]        w, m, f, r, st, sx, h;
  logic [3:0]        bank_select_register;
  logic [1:0]        s;
  logic [11:0]       p, ad, ad2, pq;
  logic [5:0]        k;
  logic [6:0]        z, z2;
  int                n_mismatch, num_checks, cyc;
  xed_core i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready), .pc_out(pc_out));
  xed_fetch_model i_mem (.clk(clk), .rst_n(rst_n), .slow(slow), .instr_ready(instr_ready),
    .instr_valid(instr_valid), .instr_word(instr_word));
  function automatic logic [11:0] eaddr(input logic a, input logic [7:0] f, input logic [3:0] b,
                                        input logic [11:0] p2, input logic ext);
    if (a) return {b, f};
    if (ext && f <= 8'h5f) return p2 + {4'h0, f};
    return (f < 8'h60) ? {4'h0, f} : {4'hf, f};
  endfunction
  function automatic logic [7:0] stat(input logic [7:0] s0, input logic [7:0] r0);
    return (s0 & 8'heb) | {3'h0, r0[7], 1'b0, r0 == 8'h0, 2'h0};
  endfunction
  task automatic bwr(input logic [3:0] ad_i, input logic [23:0] dat);
    @(posedge clk);
    bus.wr <= 1'b1; bus.addr <= ad_i; bus.wdata <= dat;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic brd(input logic [3:0] ad_i, input logic [23:0] e);
    @(posedge clk);
    bus.rd <= 1'b1; bus.addr <= ad_i;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    `CHK(bus_rdata, e)
  endtask
  task automatic mwr(input logic [11:0] ma, input logic [7:0] md);
    bwr(4'hb, {12'h0, ma}); bwr(4'hc, {16'h0, md});
  endtask
  task automatic mrd(input logic [11:0] ma, input logic [7:0] md);
    bwr(4'hb, {12'h0, ma}); brd(4'hc, {16'h0, md});
  endtask
  // A hung fetch is cut by the cycle ceiling, not here.
  task automatic exec(input logic [15:0] iw);
    i_mem.q.push_back(iw);
    exp_pc += 21'h2;
    while (i_mem.q.size() != 0) @(posedge clk);
    repeat (10) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h096e));
    rst_n = 1'b0; slow = 1'b0; bus = '0; exp_pc = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    brd(4'h0, 24'h1);
    brd(4'h1, 24'h0);
    brd(4'ha, 24'h0);
    brd(4'h9, 24'h0);
    brd(4'hd, 24'h0);
    for (int i = 0; i < 16; i++) begin
      w = 8'($urandom); m = (i == 0) ? w : 8'($urandom); f = 8'($urandom); d = 1'($urandom);
      a = (i % 4 == 1); ext = (i % 4 != 3); bank_select_register = 4'($urandom); p = 12'($urandom);
      // Only the negative and zero flags are stored, so presets touch just those bits.
      st = 8'($urandom) & 8'h14;
      if (i % 4 == 0) f[7] = 1'b1;
      if (i % 4 > 1) f = f % 8'h60;
      ad = eaddr(a, f, bank_select_register, p, ext);
      bwr(4'h0, {23'h0, ext}); bwr(4'h1, {16'h0, w}); bwr(4'h2, {16'h0, st});
      bwr(4'h3, {20'h0, bank_select_register}); bwr(4'h6, {12'h0, p}); mwr(ad, m);
      exec({6'h06, d, a, f});
      r = w ^ m;
      sx = stat(st, r);
      brd(4'h1, {16'h0, d ? w : r});
      mrd(ad, d ? r : m);
      brd(4'h2, {16'h0, sx});
    end
    slow = 1'b1;
    for (int i = 0; i < 7; i++) begin
      s = 2'(i % 3); o = (i >= 3); ext = (i < 6); p = 12'($urandom); k = 6'($urandom);
      if (i == 0) begin
        p = 12'hfff; k = 6'h3f;
      end
      bwr(4'h0, {23'h0, ext}); bwr(4'h4 + {2'h0, s}, {12'h0, p});
      exec({7'h74, o, s, k});
      pq = !ext ? p : o ? p - {6'h0, k} : p + {6'h0, k};
      brd(4'h4 + {2'h0, s}, {12'h0, pq});
    end
    bwr(4'h0, 24'h1);
    brd(4'h2, {16'h0, sx});
    for (int i = 0; i < 2; i++) begin
      w = 8'($urandom); h = 8'($urandom); p = 12'($urandom); k = 6'($urandom); o = i[0];
      bwr(4'h1, {16'h0, w}); bwr(4'h7, {16'h0, h}); bwr(4'h8, 24'h15); bwr(4'h6, {12'h0, p});
      exec(16'h0014);
      ret = exp_pc;
      exp_pc = {5'h15, h, w};
      brd(4'h9, {3'h0, exp_pc});
      brd(4'ha, {3'h0, ret});
      exec({7'h74, o, 2'h3, k});
      exp_pc = ret;
      pq = o ? p - {6'h0, k} : p + {6'h0, k};
      brd(4'h9, {3'h0, exp_pc});
      brd(4'h6, {12'h0, pq});
    end
    p = 12'($urandom); w = 8'($urandom);
    bwr(4'h6, {12'h0, p});
    exec({8'hea, w});
    mrd(p, w);
    brd(4'h6, {12'h0, p - 12'h1});
    for (int i = 0; i < 2; i++) begin
      p = 12'($urandom); z = 7'($urandom); z2 = z ^ 7'h40; m = 8'($urandom);
      ad = p + {5'h0, z};
      ad2 = (i == 1) ? p + {5'h0, z2} : ad ^ 12'h800;
      bwr(4'h6, {12'h0, p}); mwr(ad, m); mwr(ad2, ~m);
      i_mem.q.push_back({8'heb, i[0], z});
      exp_pc += 21'h2;
      exec((i == 1) ? {9'h1e0, z2} : {4'hf, ad2});
      mrd(ad2, m);
    end
    brd(4'h9, {3'h0, exp_pc});
    complete_run();
  end
endmodule // testbench
`default_nettype wire

// [testbench/xed_checker.sv]
// Concurrent checks on the ports of the decoder core.
`timescale 1ns/1ps
`default_nettype none
module xed_checker (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire xed_pkg::xed_bus_s bus,
  input wire logic [23:0]       bus_rdata,
  input wire logic              instr_valid,
  input wire logic [15:0]       instr_word,
  input wire logic              instr_ready,
  input wire logic [20:0]       pc_out
);
  // ****************************************
  // Helper logic and properties.
  // ****************************************
  logic ext_q;
  logic take;
  assign take = instr_valid && instr_ready;
  // Only bus writes move the enable bit, so a shadow copy can stand in for it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 1'b1;
    end else if (bus.wr && bus.addr == 4'h0) begin
      ext_q <= bus.wdata[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (!bus.rd |=> bus_rdata == 24'h0)
    else $error("read data shown without a read");
  chk_unmapped_zero: assert property (bus.rd && bus.addr > 4'hc |=> bus_rdata == 24'h0)
    else $error("unmapped read not zero");
  chk_cfg_read: assert property (bus.rd && bus.addr == 4'h0 |=> bus_rdata == {23'h0, ext_q})
    else $error("enable bit read wrong");
  chk_pc_read: assert property (bus.rd && bus.addr == 4'h9 |=> bus_rdata == {3'h0, $past(pc_out)})
    else $error("program counter read wrong");
  chk_pc_step: assert property (take |=> pc_out == $past(pc_out) + 21'h2)
    else $error("fetch address did not step by two");
  chk_quarter_gap: assert property (take |=> !instr_ready [*3])
    else $error("word taken inside an instruction cycle");
  chk_xor_next: assert property (take && instr_word[15:10] == 6'h06 |-> ##4 instr_ready)
    else $error("exclusive-OR not done in one cycle");
  chk_call_gap: assert property (take && instr_word == 16'h0014 && ext_q
    |=> !instr_ready [*7] ##1 instr_ready)
    else $error("call not two cycles");
  chk_return_gap: assert property (take && instr_word[15:9] == 7'h74
    && instr_word[7:6] == 2'h3 && ext_q |=> !instr_ready [*7])
    else $error("frame adjust and return not two cycles");
  chk_move_word2: assert property (take && instr_word[15:8] == 8'heb && ext_q
    |-> ##4 instr_ready)
    else $error("second move word not asked for");
  cover property (take && instr_word == 16'h0014);
  cover property (take && instr_word[15:8] == 8'heb);
  cover property (take && instr_word[15:6] == 10'h3a3);
endmodule // xed_checker
bind xed_core xed_checker i_chk (.clk(clk), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
  .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready), .pc_out(pc_out));
`default_nettype wire

// [testbench/xed_fetch_model.sv]
// Program memory fetch model that offers queued instruction words.
`timescale 1ns/1ps
`default_nettype none
module xed_fetch_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        instr_ready,
  output logic             instr_valid,
  output logic [15:0]      instr_word
);
  // ****************************************
  // Word queue and offer.
  // ****************************************
  logic [15:0] q[$];
  logic        take_n = 1'b0;
  // Ready is combinational, so the handshake is read mid-cycle once it has settled.
  always @(negedge clk) take_n = instr_valid && instr_ready;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_valid <= 1'b0;
      instr_word <= 16'h5a5a;
    end else if (!instr_valid || take_n) begin
      if (take_n) void'(q.pop_front());
      if (q.size() > 0 && !(slow && $urandom_range(2) == 0)) begin
        instr_valid <= 1'b1;
        instr_word <= q[0];
      end else begin
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
      end
    end
  end
endmodule // xed_fetch_model
`default_nettype wire
